// file: src/mts_pkg.sv
// mts_pkg: register map, field layout, reset values, codes and states
// of the multipoint trigger sequencer.
// assumes a 32-bit apb slave with byte addresses in the low 8 bits.
package mts_pkg;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CFG    = 8'h04;
    localparam logic [7:0] OFF_TCNT   = 8'h08;
    localparam logic [7:0] OFF_SCNT   = 8'h0c;
    localparam logic [7:0] OFF_TDLY   = 8'h10;
    localparam logic [7:0] OFF_SINT   = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MCOUNT = 8'h1c;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_START  = 0;
    localparam int CTRL_ABORT  = 1;
    localparam int CTRL_SWTRIG = 2;
    localparam int CFG_W       = 12;
    localparam int CFG_TSRC    = 0;
    localparam int CFG_TPOL    = 2;
    localparam int CFG_SSRC    = 3;
    localparam int CFG_SPOL    = 5;
    localparam int CFG_MCPOL   = 6;
    localparam int CFG_DEST    = 7;
    localparam int CFG_WAVE    = 11;
    localparam int ST_ERR      = 5;

    ////////////////////////////////////////////////////////////////////
    // codes
    localparam logic [1:0] SRC_IMM = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_SW  = 2'h2;
    localparam logic [1:0] SRC_INT = 2'h3;
    localparam logic [3:0] DEST_NONE = 4'h0;
    localparam logic [3:0] DEST_EXT  = 4'h1;
    localparam logic [3:0] DEST_BP0  = 4'h8;
    localparam logic [1:0] CHAS_FRONT    = 2'h1;
    localparam logic [1:0] CHAS_INTERNAL = 2'h2;
    localparam int BP_LINES = 8;

    ////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [11:0] RST_CFG  = 12'h024;
    localparam logic [15:0] RST_TCNT = 16'h0001;
    localparam logic [15:0] RST_SCNT = 16'h0001;
    localparam logic [31:0] RST_DLY  = 32'h0000_0000;
    localparam int MC_WIDTH_DEF = 4;
    localparam int SYNC_STAGES  = 3;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WTRIG = 5'h02,
        ST_DELAY = 5'h04,
        ST_MEAS  = 5'h08,
        ST_WSMP  = 5'h10
    } mts_state_t;

endpackage : mts_pkg

// file: src/mts_sequencer.sv
// mts_sequencer: two-level trigger/sample-trigger acquisition sequencer
// with apb registers and a measurement-done pulse router.
// assumes the analog front end answers measStart with one measDone pulse
// on ref_clk; trigger pins are asynchronous to ref_clk.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module mts_sequencer #(
    parameter int CNT_W = 16,
    parameter int MC_W  = mts_pkg::MC_WIDTH_DEF
) (
    input  wire logic                         ref_clk,
    input  wire logic                         resetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         extTrigIn,
    input  wire logic                         extSmpTrigIn,
    input  wire logic [1:0]                   chassisCtl,
    input  wire logic                         measDone,
    output logic                              measStart,
    output logic                              busy,
    output logic                              mcExtPin,
    output logic [mts_pkg::BP_LINES-1:0]      backplaneTriggerLine
);
    import mts_pkg::*;

    if (CNT_W < 1 || CNT_W > 16) begin : gChkCnt
        $error("CNT_W must lie in 1..16");
    end
    if (MC_W < 1 || MC_W > 255) begin : gChkMc
        $error("MC_W must lie in 1..255");
    end

    ////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic edgeHit(input logic prev, input logic cur,
                                     input logic rising);
        edgeHit = rising ? (cur & ~prev) : (~cur & prev);
    endfunction : edgeHit

    function automatic logic srcHit(input logic [1:0] src,
                                    input logic ext, input logic sw,
                                    input logic timer);
        case (src)
            SRC_IMM: srcHit = 1'b1;
            SRC_EXT: srcHit = ext;
            SRC_SW:  srcHit = sw;
            default: srcHit = timer;
        endcase
    endfunction : srcHit

    function automatic logic [31:0] loadDly(input logic [31:0] v);
        loadDly = (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction : loadDly

    ////////////////////////////////////////////////////////////////////
    // registers
    mts_state_t           st_r, stNxt;
    logic [CFG_W-1:0]     cfg_r;
    logic [CNT_W-1:0]     tcnt_r, scnt_r, smpCnt_r, trigRcvd_r;
    logic [31:0]          tdly_r, sint_r, dly_r, prdata_r;
    logic                 pready_r, pslverr_r, err_r, initDone_r;
    logic                 measStart_r, measStartNxt, busy_r, mcExt_r;
    logic [BP_LINES-1:0]  bp_r;
    logic [7:0]           mcCnt_r;
    logic [SYNC_STAGES-1:0] tSync_r, sSync_r;
    logic                 tStable_r, sStable_r, mcFire;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    wire        setup   = psel & ~penable;
    wire        wrEn    = psel & penable & pready_r & pwrite;
    wire        selCtrl = paddr == OFF_CTRL;
    wire        selCfg  = paddr == OFF_CFG;
    wire        selTcnt = paddr == OFF_TCNT;
    wire        selScnt = paddr == OFF_SCNT;
    wire        selTdly = paddr == OFF_TDLY;
    wire        selSint = paddr == OFF_SINT;
    wire        selStat = paddr == OFF_STATUS;
    wire        selMcnt = paddr == OFF_MCOUNT;
    wire        mapped  = selCtrl | selCfg | selTcnt | selScnt | selTdly
                        | selSint | selStat | selMcnt;
    wire [31:0] rdMux   =
        selCfg  ? {20'h0, cfg_r} :
        selTcnt ? 32'(tcnt_r) :
        selScnt ? 32'(scnt_r) :
        selTdly ? tdly_r :
        selSint ? sint_r :
        selStat ? {26'h0, err_r, st_r} :
        selMcnt ? {16'(trigRcvd_r), 16'(smpCnt_r)} : 32'h0;

    wire ctrlWr   = wrEn & selCtrl;
    wire startReq = ctrlWr & pwdata[CTRL_START];
    wire abortReq = ctrlWr & pwdata[CTRL_ABORT];
    wire swTrig   = ctrlWr & pwdata[CTRL_SWTRIG];

    ////////////////////////////////////////////////////////////////////
    // config fields
    wire [1:0] trigSrc  = cfg_r[CFG_TSRC +: 2];
    wire       trigPol  = cfg_r[CFG_TPOL];
    wire [1:0] smpSrc   = cfg_r[CFG_SSRC +: 2];
    wire       smpPol   = cfg_r[CFG_SPOL];
    wire       mcPos    = cfg_r[CFG_MCPOL];
    wire [3:0] mcDest   = cfg_r[CFG_DEST +: 4];
    wire       waveMode = cfg_r[CFG_WAVE];
    wire [3:0] destDef  = (chassisCtl == CHAS_FRONT)    ? DEST_EXT :
                          (chassisCtl == CHAS_INTERNAL) ? DEST_BP0 :
                          DEST_NONE;

    ////////////////////////////////////////////////////////////////////
    // trigger pin synchronisers: a level counts once stages 2 and 3 agree
    wire tNew  = (tSync_r[1] == tSync_r[2]) ? tSync_r[2] : tStable_r;
    wire sNew  = (sSync_r[1] == sSync_r[2]) ? sSync_r[2] : sStable_r;
    wire tEdge = edgeHit(tStable_r, tNew, trigPol);
    wire sEdge = edgeHit(sStable_r, sNew, smpPol);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tSync_r   <= '0;
            sSync_r   <= '0;
            tStable_r <= 1'b0;
            sStable_r <= 1'b0;
        end else begin
            tSync_r   <= {tSync_r[1:0], extTrigIn};
            sSync_r   <= {sSync_r[1:0], extSmpTrigIn};
            tStable_r <= tNew;
            sStable_r <= sNew;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencing terms
    wire dlyZero  = dly_r == 32'h0;
    // an interval source on the main input behaves as immediate
    wire trigEvt  = srcHit(trigSrc, tEdge, swTrig, 1'b1);
    wire smpEvt   = srcHit(smpSrc, sEdge, swTrig, dlyZero);
    wire contBad  = waveMode & (tcnt_r == '0 | scnt_r == '0);
    wire inIdle   = st_r == ST_IDLE;
    wire startOk  = startReq & inIdle & ~contBad & ~abortReq;
    wire [CNT_W-1:0] smpInc = smpCnt_r + CNT_W'(1);
    wire innerDone = (scnt_r != '0) & (smpInc == scnt_r);
    wire outerDone = (tcnt_r != '0) & (trigRcvd_r == tcnt_r);
    wire measTaken = (st_r == ST_MEAS) & measDone;

    always_comb begin
        stNxt        = st_r;
        measStartNxt = 1'b0;
        mcFire       = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (startOk) begin
                    stNxt = ST_WTRIG;
                end
            end
            ST_WTRIG: begin
                if (trigEvt) begin
                    stNxt        = (tdly_r == 32'h0) ? ST_MEAS : ST_DELAY;
                    measStartNxt = tdly_r == 32'h0;
                end
            end
            ST_DELAY: begin
                if (dlyZero) begin
                    stNxt        = ST_MEAS;
                    measStartNxt = 1'b1;
                end
            end
            ST_MEAS: begin
                if (measDone) begin
                    mcFire = ~waveMode | (innerDone & outerDone);
                    if (!innerDone) begin
                        stNxt = ST_WSMP;
                    end else if (outerDone) begin
                        stNxt = ST_IDLE;
                    end else begin
                        stNxt = ST_WTRIG;
                    end
                end
            end
            ST_WSMP: begin
                if (smpEvt) begin
                    stNxt        = ST_MEAS;
                    measStartNxt = 1'b1;
                end
            end
            default: stNxt = ST_IDLE;
        endcase
        if (abortReq) begin
            stNxt        = ST_IDLE;
            measStartNxt = 1'b0;
            mcFire       = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state, counters, delay timer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r        <= ST_IDLE;
            measStart_r <= 1'b0;
            busy_r      <= 1'b0;
        end else begin
            st_r        <= stNxt;
            measStart_r <= measStartNxt;
            busy_r      <= stNxt != ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            smpCnt_r   <= '0;
            trigRcvd_r <= '0;
        end else if (startOk) begin
            smpCnt_r   <= '0;
            trigRcvd_r <= '0;
        end else begin
            if (st_r == ST_WTRIG && trigEvt) begin
                trigRcvd_r <= trigRcvd_r + CNT_W'(1);
            end
            if (measTaken) begin
                smpCnt_r <= innerDone ? '0 : smpInc;
            end
        end
    end

    // one down-counter serves the trigger delay and the sample interval
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dly_r <= RST_DLY;
        end else if (st_r == ST_WTRIG) begin
            dly_r <= loadDly(tdly_r);
        end else if (measTaken) begin
            dly_r <= loadDly(sint_r);
        end else if (!dlyZero) begin
            dly_r <= dly_r - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb register file
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r  <= (setup & ~pwrite) ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r      <= RST_CFG;
            initDone_r <= 1'b0;
        end else if (!initDone_r) begin
            // strap caught on the first edge after reset release
            cfg_r[CFG_DEST +: 4] <= destDef;
            initDone_r           <= 1'b1;
        end else if (wrEn && selCfg) begin
            cfg_r <= pwdata[CFG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= RST_TCNT[CNT_W-1:0];
            scnt_r <= RST_SCNT[CNT_W-1:0];
            tdly_r <= RST_DLY;
            sint_r <= RST_DLY;
        end else if (wrEn) begin
            if (selTcnt) tcnt_r <= pwdata[CNT_W-1:0];
            if (selScnt) scnt_r <= pwdata[CNT_W-1:0];
            if (selTdly) tdly_r <= pwdata;
            if (selSint) sint_r <= pwdata;
        end
    end

    // refused start is the only setter, accepted start the only clearer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_r <= 1'b0;
        end else if (startReq && inIdle && contBad) begin
            err_r <= 1'b1;
        end else if (startOk) begin
            err_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurement-done pulse: fixed width, one destination, polarity
    wire       mcOn = mcCnt_r != 8'h0;
    wire [BP_LINES-1:0] bpHit = (mcOn && mcDest[3])
        ? (BP_LINES'(1) << mcDest[2:0]) : '0;
    wire       extHit = mcOn & (mcDest == DEST_EXT);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mcCnt_r <= 8'h0;
            mcExt_r <= 1'b1;
            bp_r    <= '1;
        end else begin
            if (mcFire) begin
                mcCnt_r <= 8'(MC_W);
            end else if (mcOn) begin
                mcCnt_r <= mcCnt_r - 8'h1;
            end
            mcExt_r <= mcPos ? extHit : ~extHit;
            bp_r    <= mcPos ? bpHit : ~bpHit;
        end
    end

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign measStart            = measStart_r;
    assign busy                 = busy_r;
    assign mcExtPin             = mcExt_r;
    assign backplaneTriggerLine = bp_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seqTrigTaken;
        st_r == ST_WTRIG && trigEvt && !abortReq && tdly_r != 32'h0;
    endsequence

    sequence seqDelayRun;
        st_r == ST_DELAY && !measStart_r;
    endsequence

    chk_delay_load: assert property (seqTrigTaken |=>
        seqDelayRun and (dly_r == tdly_r - 32'h1))
        else $error("trigger delay not loaded");

    chk_delay_end: assert property (st_r == ST_DELAY && dlyZero
        && !abortReq |=> measStart_r)
        else $error("measurement not started after delay ran out");

    chk_start_wait: assert property (startOk |=> st_r == ST_WTRIG
        && !measStart_r)
        else $error("start did not enter wait-for-trigger");

    chk_idle_quiet: assert property (inIdle |-> ##1 !measStart_r)
        else $error("measurement started from idle");

    chk_abort_idle: assert property (abortReq |=> inIdle ##1 !busy_r)
        else $error("abort did not return to idle");

    chk_cont_wave: assert property (startReq && inIdle && contBad
        |=> inIdle && err_r)
        else $error("continuous start accepted in waveform mode");

    chk_imm_sample: assert property (st_r == ST_WSMP
        && smpSrc == SRC_IMM && !abortReq |=> measStart_r)
        else $error("immediate sample trigger did not measure");

    chk_finite_end: assert property (measTaken && innerDone
        && outerDone && !abortReq |=> inIdle)
        else $error("finite acquisition did not end");

    chk_outer_loop: assert property (measTaken && innerDone
        && !outerDone && !abortReq |=> st_r == ST_WTRIG)
        else $error("outer loop did not return to wait");

    chk_inner_loop: assert property (measTaken && !innerDone
        && !abortReq |=> st_r == ST_WSMP)
        else $error("inner loop ended early");

    chk_mc_width: assert property (mcFire |=> mcCnt_r == 8'(MC_W)
        ##1 mcOn)
        else $error("done pulse width wrong");

    // polarity must hold across the edge that registers the pin
    chk_mc_polarity: assert property (!mcOn ##1 $stable(mcPos)
        |-> mcExt_r == ~mcPos)
        else $error("done pulse idle level wrong");

    chk_wave_single: assert property (measTaken && waveMode
        && !(innerDone && outerDone) |-> !mcFire)
        else $error("point pulse issued in waveform mode");

endmodule : mts_sequencer

// file: tb/mts_partner.sv
// mts_partner: front end answering measStart, main trigger source, and
// a switch module counting measurement_done_pulse falling edges.
// assumes ref_clk and a level on the done pin; no apb access.
`timescale 1ns/1ps

module mts_partner (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        measStart,
    input  wire logic        fire,
    input  wire logic        mcIn,
    output logic             measDone,
    output logic             extTrigIn,
    output logic [15:0]      falls
);
    logic [1:0] lat;
    logic [3:0] hold;
    logic       mcPrev;

    ////////////////////////////////////////////////////////////////////
    // wide trigger pulse so either edge polarity is told apart in time
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lat       <= 2'h0;
            measDone  <= 1'b0;
            hold      <= 4'h0;
            extTrigIn <= 1'b0;
            mcPrev    <= 1'b1;
            falls     <= 16'h0000;
        end else begin
            lat       <= {lat[0], measStart};
            measDone  <= lat[1];
            hold      <= fire ? 4'hc : (hold != 4'h0 ? hold - 4'h1 : hold);
            extTrigIn <= fire || (hold > 4'h1);
            mcPrev    <= mcIn;
            if (mcPrev && !mcIn) begin
                falls <= falls + 16'h0001;
            end
        end
    end
endmodule : mts_partner

// file: tb/test_multipoint_trigger_sequencer.sv
// test_multipoint_trigger_sequencer: directed scenarios over apb.
// assumes mts_partner as front end and switch; bench drives the strap.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %h exp %h", $time, (a), (b)); end end

module test_multipoint_trigger_sequencer;
    import mts_pkg::*;
    logic        ref_clk, resetn, psel, penable, pwrite, fire;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, rerr, extTrigIn, measDone, measStart;
    logic        busy, mcExtPin;
    logic [7:0]  bpl;
    logic [1:0]  chassis;
    logic [15:0] falls, f0;
    int          fails, compares, nMeas, n;

    mts_sequencer i_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extTrigIn(extTrigIn), .extSmpTrigIn(1'b0),
        .chassisCtl(chassis), .measDone(measDone),
        .measStart(measStart), .busy(busy), .mcExtPin(mcExtPin),
        .backplaneTriggerLine(bpl));
    mts_partner i_part (.ref_clk(ref_clk), .resetn(resetn),
        .measStart(measStart), .fire(fire), .mcIn(mcExtPin),
        .measDone(measDone), .extTrigIn(extTrigIn), .falls(falls));

    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (measStart === 1'b1) nMeas <= nMeas + 1;

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : cyc
    task waitIdle;
        cyc(4);
        while (busy !== 1'b0) @(posedge ref_clk);
        // last done pulse ends a few cycles after idle
        cyc(8);
    endtask : waitIdle
    task run(input logic [31:0] cfg, input logic [31:0] tc, sc);
        apb(1, OFF_CFG, cfg); apb(1, OFF_TCNT, tc); apb(1, OFF_SCNT, sc);
        nMeas = 0;
        f0 = falls;
        apb(1, OFF_CTRL, 32'h1);
    endtask : run

    ////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, OFF_CFG, 0);  `CHK(rdat, 32'h0a4)
        apb(0, OFF_TCNT, 0); `CHK(rdat, 32'h1)
        apb(0, 8'h40, 0);    `CHK(rerr, 1'b1)
        `CHK(mcExtPin, 1'b1)
    endtask : t_reset
    task t_finite;
        run(32'h0a4, 2, 3); waitIdle;
        `CHK(nMeas, 6)
        `CHK(falls - f0, 16'h6)
        apb(0, OFF_STATUS, 0); `CHK(rdat, 32'h1)
        apb(1, OFF_CFG, 32'h0e4); cyc(3); `CHK(mcExtPin, 1'b0)
    endtask : t_finite
    task t_delay_sw;
        apb(1, OFF_TDLY, 20); run(32'h0a6, 1, 1);
        cyc(10); `CHK(nMeas, 0)
        apb(1, OFF_CTRL, 32'h4);
        cyc(10); `CHK(nMeas, 0)
        cyc(30); `CHK(nMeas, 1)
        waitIdle; apb(1, OFF_TDLY, 0);
    endtask : t_delay_sw
    task t_ext;
        run(32'h0a1, 1, 1);
        fire <= 1'b1; cyc(1); fire <= 1'b0;
        cyc(10); `CHK(nMeas, 0)
        cyc(20); `CHK(nMeas, 1)
        waitIdle;
    endtask : t_ext
    task t_interval;
        apb(1, OFF_SINT, 30); run(32'h0bc, 1, 2);
        cyc(20); `CHK(nMeas, 1)
        cyc(40); `CHK(nMeas, 2)
        waitIdle;
    endtask : t_interval
    task t_wave;
        run(32'h8a4, 1, 3); waitIdle;
        `CHK(nMeas, 3)
        `CHK(falls - f0, 16'h1)
    endtask : t_wave
    task t_bp;
        run(32'h5e4, 1, 1);
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            if (bpl == 8'h08) n++;
        end
        `CHK(n, MC_WIDTH_DEF)
        `CHK(bpl, 8'h00)
        `CHK(mcExtPin, 1'b0)
        waitIdle;
    endtask : t_bp
    task t_strap;
        chassis <= CHAS_INTERNAL;
        cyc(1);
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(2);
        apb(0, OFF_CFG, 0); `CHK(rdat, 32'h424)
        chassis <= 2'h0;
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(2);
        apb(0, OFF_CFG, 0); `CHK(rdat, 32'h024)
    endtask : t_strap
    task t_cont;
        for (int i = 0; i < 2; i++) begin
            run(32'h0a4, i, 1 - i); cyc(60);
            `CHK(nMeas > 5, 1'b1)
            apb(1, OFF_CTRL, 32'h2); cyc(4);
            apb(0, OFF_STATUS, 0); `CHK(rdat, 32'h1)
            n = nMeas; cyc(20); `CHK(nMeas, n)
        end
    endtask : t_cont
    task t_refuse;
        run(32'h8a4, 1, 0); cyc(8);
        apb(0, OFF_STATUS, 0); `CHK(rdat, 32'h21)
        `CHK(nMeas, 0)
    endtask : t_refuse

    task print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    initial begin
        cyc(20000);
        fails++;
        print_verdict;
    end
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; fire = 1'b0; nMeas = 0;
        chassis = CHAS_FRONT;
        fails = 0; compares = 0;
        cyc(20);
        resetn <= 1'b1;
        cyc(2);
        t_reset; t_finite; t_delay_sw; t_ext; t_interval; t_wave;
        t_bp; t_cont; t_refuse; t_strap;
        print_verdict;
    end
endmodule : test_multipoint_trigger_sequencer
